//--- hdl/tsec_pkg.sv
// package: register map, levels, default routing for the event controller
package tsec_pkg;
  localparam int NUM_SRC = 32;
  localparam int NUM_EVT = 16;
  localparam int GP_FIRST = 7;
  localparam int GP_COUNT = 9;
  localparam int ASSIGN_W = 4;
  localparam int SRC_PER_ASSIGN = 8;
  localparam int NUM_ASSIGN = 4;
  // event numbers (priority, 0 highest)
  localparam int EVT_EMU = 0;
  localparam int EVT_RST = 1;
  localparam int EVT_NMI = 2;
  localparam int EVT_EXC = 3;
  localparam int EVT_RSVD = 4;
  localparam int EVT_HWE = 5;
  localparam int EVT_TMR = 6;
  // byte addresses on the register bus
  localparam logic [11:0] OFF_LATCH = 12'h000;
  localparam logic [11:0] OFF_UNMASK = 12'h004;
  localparam logic [11:0] OFF_ACTIVE = 12'h008;
  localparam logic [11:0] OFF_SYS_UNMASK = 12'h010;
  localparam logic [11:0] OFF_SYS_STATUS = 12'h014;
  localparam logic [11:0] OFF_WAKE_EN = 12'h018;
  localparam logic [11:0] OFF_ASSIGN0 = 12'h020;
  localparam logic [11:0] OFF_CTRL = 12'h030;
  // control register fields
  localparam int CTRL_GEN = 0;
  localparam int CTRL_SUP = 1;
  // reset values
  localparam logic [31:0] RST_UNMASK = 32'h0000_001f;
  localparam logic [31:0] RST_SYS_UNMASK = 32'h0000_0000;
  localparam logic [31:0] RST_WAKE_EN = 32'h0000_0000;
  // default routing, level minus seven, eight 4-bit fields per register
  localparam logic [31:0] RST_ASSIGN0 = 32'h2221_1000;
  localparam logic [31:0] RST_ASSIGN1 = 32'h3333_3332;
  localparam logic [31:0] RST_ASSIGN2 = 32'h5555_5444;
  localparam logic [31:0] RST_ASSIGN3 = 32'h6665_5555;
  // packed bus request
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } tsec_apb_req_s;
endpackage : tsec_pkg

//--- hdl/tsec_top.sv
// two-stage event controller: system routing stage plus core event stage
// Behaviour
// RL1: nine general-purpose levels, seven to fifteen, beside dedicated events.
// RL2: fixed priorities, zero highest; emulation, reset, nmi, exception, ...
// RL3: software keeps levels fourteen and fifteen for software handlers.
// RL4: every source routes to a general-purpose level set by software.
// RL5: reset routing follows the fixed default source-to-level table.
// RL6: software can see which shared source raised an interrupt.
// RL7: core stage holds latch, unmask and active registers, 32 bits.
// RL8: latch set on event, cleared on accept; writable only when masked.
// RL9: set unmask bit allows servicing; clear bit blocks it.
// RL10: core unmask register accessible only in supervisor mode.
// RL11: global enable and disable gate all general-purpose levels.
// RL12: active register marks nested events, hardware-only, supervisor read.
// RL13: system stage holds unmask, status and wake enable, one bit each.
// RL14: set system unmask bit lets a source through; clear blocks it.
// RL15: status bit reads one while its source asserts.
// RL16: enabled source asserting while core idles wakes the processor.
// RL17: latch sets on rising edge, detection takes two cycles.
// RL18: latch clears as active sets; next edge then queued.
// RL19: at least three cycles from rising edge to active bit.
// RL20: system stage uses active bits as acknowledgement; here no system-stage logic reads them.
// RL21: nesting and prioritisation; several handlers active at once.
// RL22: select highest latched, unmasked event above all active ones.
// RL23: each assignment field holds level minus seven for one source.
//
// datapath overview, one request from pin to pipeline:
//   cycle 0: a routed source or dedicated input rises
//   cycle 1: input registered and compared with its previous value
//   cycle 2: latch bit set, offer shown if unmasked and above all active
//   cycle 3: earliest accept lands; active bit sets, latch bit clears
// the offer is combinational so the pipeline sees it the cycle it forms;
// everything feeding it is registered, which keeps the path short.
//
// register map, one aligned 32-bit word each:
//   latch, unmask, active          core stage, supervisor only
//   system unmask, status, wake    system stage, always reachable
//   four assignment words          eight 4-bit level codes per word
//   control                        global enable and supervisor view
//
// limitations a user must know:
//   no wait states and no error answer; unmapped words read as zero
//   assignment codes above eight alias past level fifteen
//   a source held high gives one event; it must fall to be seen again
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
module tsec_top (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // peripheral sources and dedicated events
  input wire logic [31:0] SRC_IRQ,
  input wire logic [6:0] DED_EVT,
  input wire logic [1:0] SW_IRQ,
  // core pipeline side
  input wire logic SUPERVISOR,
  input wire logic GLOBAL_ENABLE,
  input wire logic GLOBAL_DISABLE,
  input wire logic CORE_IDLE,
  input wire logic EVT_ACCEPT,
  input wire logic EVT_RETURN,
  input wire logic [3:0] RETURN_NUM,
  output logic EVT_REQ,
  output logic [3:0] EVT_NUM,
  output logic WAKEUP
);
  logic rst_meta_q;
  logic rst_sync_q;
  tsec_pkg::tsec_apb_req_s req;
  logic [31:0] latch_q;
  logic [31:0] unmask_q;
  logic [31:0] active_q;
  logic [31:0] sys_unmask_q;
  logic [31:0] wake_en_q;
  logic [31:0] assign_q [tsec_pkg::NUM_ASSIGN];
  logic gen_q;
  logic [15:0] raw_in;
  logic [15:0] in_q;
  logic [15:0] rise_q;
  logic [15:0] gp_route;
  logic [15:0] cand;
  logic [15:0] accept_vec;
  logic [15:0] ret_vec;
  logic wr;
  logic rd_ok;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [3:0] sel_num;
  logic sel_ok;

  // level of source s: assignment field plus seven
  function automatic logic [3:0] src_level(
    input logic [31:0] regs [tsec_pkg::NUM_ASSIGN], input int s);
    logic [3:0] f;
    f = regs[s / tsec_pkg::SRC_PER_ASSIGN][(s % 8) * 4 +: 4];
    return 4'(f + 4'(tsec_pkg::GP_FIRST)); // RL23
  endfunction : src_level

  // completed bus write to one word; shared by several registers
  function automatic logic wr_hit(input logic wr_en,
    input logic [11:0] a, input logic [11:0] off);
    return wr_en && (a == off);
  endfunction : wr_hit

  // reset release through two flops
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign req = '{PSEL, PENABLE, PWRITE, PADDR, PWDATA};
  // zero-wait slave: every access completes in its first access cycle
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign wr = req.sel && req.enable && req.write;

  // routing of unmasked sources onto levels seven..thirteen and beyond
  always_comb begin
    gp_route = '0;
    for (int s = 0; s < tsec_pkg::NUM_SRC; s++) begin
      if (SRC_IRQ[s] && sys_unmask_q[s]) begin // RL14
        gp_route[src_level(assign_q, s)] = 1'b1; // RL4
      end
    end
    gp_route[15:14] = gp_route[15:14] | SW_IRQ; // RL3
    gp_route[tsec_pkg::EVT_RSVD] = 1'b0;
  end

  // dedicated inputs 0..6 but reserved 4, plus routed general-purpose levels
  always_comb begin
    raw_in = gp_route;
    for (int e = 0; e < tsec_pkg::GP_FIRST; e++) begin
      if (e != tsec_pkg::EVT_RSVD) begin
        raw_in[e] = DED_EVT[e]; // RL2
      end
    end
  end

  // two-stage edge detection, register input then compare
  // levels are turned into edges here so a source that stays high
  // after its handler runs is not taken twice; the price is that a
  // pulse shorter than one clock may be missed
  always_ff @(posedge MCLK or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      in_q <= '0;
      rise_q <= '0;
    end else begin
      in_q <= raw_in;
      rise_q <= raw_in & ~in_q; // RL17
    end
  end

  // candidates: latched, unmasked, globally enabled at levels 7..15, above every active
  // the scan runs from lowest to highest priority so the last hit wins;
  // an active bit at or above a candidate blocks it, which gives nesting
  // without a separate stack in this block
  always_comb begin
    cand = '0;
    sel_ok = 1'b0;
    sel_num = '0;
    for (int e = 0; e < tsec_pkg::NUM_EVT; e++) begin
      cand[e] = latch_q[e] && unmask_q[e]; // RL9
      if (e >= tsec_pkg::GP_FIRST && !gen_q) begin
        cand[e] = 1'b0; // RL11
      end
    end
    for (int e = tsec_pkg::NUM_EVT - 1; e >= 0; e--) begin
      if (cand[e] && (active_q[15:0] & ((16'h0001 << e) - 16'h0001)) == '0
          && !active_q[e]) begin
        sel_ok = 1'b1; // RL22
        sel_num = 4'(e); // RL21
      end
    end
  end

  assign EVT_REQ = sel_ok;
  assign EVT_NUM = sel_num;

  always_comb begin
    accept_vec = '0;
    ret_vec = '0;
    if (EVT_ACCEPT && sel_ok) begin
      accept_vec[sel_num] = 1'b1;
    end
    if (EVT_RETURN) begin
      ret_vec[RETURN_NUM] = 1'b1;
    end
  end

  // latch: set on edge beats clear on accept; sw write only when masked
  // a new edge in the accept cycle must not be lost, hence set first;
  // software may only touch masked bits so it cannot race the offer
  always_ff @(posedge MCLK or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      latch_q <= '0;
    end else begin
      for (int e = 0; e < tsec_pkg::NUM_EVT; e++) begin
        if (rise_q[e]) begin
          latch_q[e] <= 1'b1; // RL8
        end else if (accept_vec[e]) begin
          latch_q[e] <= 1'b0; // RL18
        end else if (wr_hit(wr, req.addr, tsec_pkg::OFF_LATCH) && SUPERVISOR
                     && !unmask_q[e]) begin
          latch_q[e] <= req.wdata[e]; // RL8
        end
      end
      latch_q[31:16] <= '0;
      latch_q[tsec_pkg::EVT_RSVD] <= 1'b0;
    end
  end

  // active: hardware only, set on accept, cleared on return; nests
  // no system-stage logic reads a set bit here; the latch of the level
  // clears on the accept itself and can take the next edge from then on
  always_ff @(posedge MCLK or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      active_q <= '0;
    end else begin
      active_q[15:0] <= (active_q[15:0] & ~ret_vec) | accept_vec; // RL12
      // edge to active is at least three cycles: rise_q, latch, active
      active_q[31:16] <= '0; // RL19
    end
  end

  // software-written state
  // only complete access cycles write, so a setup alone changes nothing;
  // the unmask word keeps its lowest four events on whatever is written
  always_ff @(posedge MCLK or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      unmask_q <= tsec_pkg::RST_UNMASK;
      sys_unmask_q <= tsec_pkg::RST_SYS_UNMASK;
      wake_en_q <= tsec_pkg::RST_WAKE_EN;
      assign_q[0] <= tsec_pkg::RST_ASSIGN0; // RL5
      assign_q[1] <= tsec_pkg::RST_ASSIGN1;
      assign_q[2] <= tsec_pkg::RST_ASSIGN2;
      assign_q[3] <= tsec_pkg::RST_ASSIGN3;
    end else if (wr) begin
      unique case (req.addr)
        tsec_pkg::OFF_UNMASK: begin
          if (SUPERVISOR) begin
            // unmaskable events 0..3 stay enabled
            unmask_q <= {16'h0000, req.wdata[15:0]} | 32'h0000_000f; // RL10
          end
        end
        tsec_pkg::OFF_SYS_UNMASK: sys_unmask_q <= req.wdata; // RL13
        tsec_pkg::OFF_WAKE_EN: wake_en_q <= req.wdata;
        tsec_pkg::OFF_ASSIGN0: assign_q[0] <= req.wdata;
        tsec_pkg::OFF_ASSIGN0 + 12'h004: assign_q[1] <= req.wdata;
        tsec_pkg::OFF_ASSIGN0 + 12'h008: assign_q[2] <= req.wdata;
        tsec_pkg::OFF_ASSIGN0 + 12'h00c: assign_q[3] <= req.wdata;
        default: ;
      endcase
    end
  end

  // global enable: set instruction wins over clear instruction
  always_ff @(posedge MCLK or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      gen_q <= 1'b0;
    end else if (GLOBAL_ENABLE) begin
      gen_q <= 1'b1; // RL11
    end else if (GLOBAL_DISABLE) begin
      gen_q <= 1'b0;
    end else if (wr_hit(wr, req.addr, tsec_pkg::OFF_CTRL)) begin
      gen_q <= req.wdata[tsec_pkg::CTRL_GEN];
    end
  end

  // wake-up: any enabled source while the core idles
  // registered so the power control sees a clean level; it ignores the
  // system unmask on purpose, a masked source may still wake the core
  always_ff @(posedge MCLK or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      WAKEUP <= 1'b0;
    end else begin
      WAKEUP <= CORE_IDLE && |(SRC_IRQ & wake_en_q); // RL16
    end
  end

  // read mux; core registers read as zero outside supervisor mode
  // status reads the raw source pins so software can tell which of
  // several sources sharing a level is asking
  always_comb begin
    rd_ok = SUPERVISOR;
    rdata_d = '0;
    unique case (req.addr)
      tsec_pkg::OFF_LATCH: rdata_d = rd_ok ? latch_q : '0; // RL7
      tsec_pkg::OFF_UNMASK: rdata_d = rd_ok ? unmask_q : '0; // RL10
      tsec_pkg::OFF_ACTIVE: rdata_d = rd_ok ? active_q : '0; // RL20
      tsec_pkg::OFF_SYS_UNMASK: rdata_d = sys_unmask_q;
      tsec_pkg::OFF_SYS_STATUS: rdata_d = SRC_IRQ; // RL15 RL6
      tsec_pkg::OFF_WAKE_EN: rdata_d = wake_en_q;
      tsec_pkg::OFF_ASSIGN0: rdata_d = assign_q[0];
      tsec_pkg::OFF_ASSIGN0 + 12'h004: rdata_d = assign_q[1];
      tsec_pkg::OFF_ASSIGN0 + 12'h008: rdata_d = assign_q[2];
      tsec_pkg::OFF_ASSIGN0 + 12'h00c: rdata_d = assign_q[3];
      tsec_pkg::OFF_CTRL: rdata_d = {30'h0, SUPERVISOR, gen_q};
      default: rdata_d = '0;
    endcase
  end

  // read data registered at setup so it stands in the access cycle
  // it then holds until the next read setup, never changing mid-access
  always_ff @(posedge MCLK or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= '0;
    end else if (req.sel && !req.enable && !req.write) begin
      rdata_q <= rdata_d;
    end
  end
  assign PRDATA = rdata_q;
  // RL1: levels 7..15 are bits 7..15 of latch, unmask and active
endmodule : tsec_top

//--- verification/tsec_monitor.sv
// checker: bus answer, event offer and wake-up relations at the top ports
`timescale 1ns/1ps
module tsec_monitor (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // register bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // sources and pipeline
  input wire logic [31:0] SRC_IRQ,
  input wire logic CORE_IDLE,
  input wire logic GLOBAL_ENABLE,
  input wire logic GLOBAL_DISABLE,
  input wire logic EVT_ACCEPT,
  input wire logic EVT_RETURN,
  input wire logic EVT_REQ,
  input wire logic [3:0] EVT_NUM,
  input wire logic WAKEUP
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // event taken with no return beside it
  sequence s_taken;
    EVT_ACCEPT && EVT_REQ && !EVT_RETURN;
  endsequence
  // disable pulse not overridden in the same cycle
  sequence s_gdis;
    GLOBAL_DISABLE && !GLOBAL_ENABLE && !(PSEL && PENABLE && PWRITE);
  endsequence
  a_bus_ready: assert property (PSEL |-> PREADY)
    else $error("wait state inserted");
  a_no_error: assert property (PSEL && PENABLE |-> !PSLVERR)
    else $error("bus error answered");
  a_rdata_hold: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
    else $error("read data moved outside a read setup");
  a_reset_quiet: assert property ($rose(RST_B) |-> (!EVT_REQ && !WAKEUP)[*2])
    else $error("event or wake-up right after reset");
  a_rsvd_never: assert property (EVT_REQ |-> EVT_NUM != 4'h4)
    else $error("reserved level offered");
  a_accept_higher: assert property (s_taken |=> !EVT_REQ || EVT_NUM < $past(EVT_NUM))
    else $error("offer not above the taken event");
  a_gdis_block: assert property (s_gdis |=> !(EVT_REQ && EVT_NUM >= 4'h7))
    else $error("general level offered while disabled");
  a_wake_cause: assert property ($rose(WAKEUP) |-> $past(CORE_IDLE && SRC_IRQ != 32'h0))
    else $error("wake-up without idle source");
endmodule : tsec_monitor
bind tsec_top tsec_monitor i_mon (.*);

//--- verification/tsec_core_model.sv
// pipeline partner: takes offered events, retires them on command
`timescale 1ns/1ps
module tsec_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // offered event
  input wire logic req,
  input wire logic [3:0] num,
  // bench controls: stall taking, retire newest
  input wire logic hold,
  input wire logic pop,
  // answer to the controller
  output logic accept,
  output logic ret,
  output logic [3:0] ret_num
);
  logic [3:0] stk_q [8];
  int sp_q;
  // gap after each take so the latch can clear before the next offer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accept <= 1'b0;
      ret <= 1'b0;
      ret_num <= 4'h0;
      sp_q <= 0;
    end else begin
      accept <= req && !hold && !accept;
      ret <= pop && sp_q > 0 && !accept;
      ret_num <= ~ret_num; // no stale number between returns
      if (accept) begin
        stk_q[sp_q] <= num;
        sp_q <= sp_q + 1;
      end else if (pop && sp_q > 0) begin
        ret_num <= stk_q[sp_q-1];
        sp_q <= sp_q - 1;
      end
    end
  end
endmodule : tsec_core_model

//--- verification/tsec_top_tb.sv
// testbench: registers, routing, latch, nesting and wake-up
`timescale 1ns/1ps
module tsec_top_tb;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, src = 32'h0, rd, prdata;
  logic [31:0] ex [4];
  logic [6:0] ded = 7'h00;
  logic [1:0] sw = 2'h0;
  logic sup = 1'b1, gen = 1'b0, gdis = 1'b0, idle = 1'b0;
  logic hold = 1'b1, pop = 1'b0, pready, pslverr, acc, ret, req, wake;
  logic [3:0] rnum, num;
  int failures = 0, tests_run = 0;
  always #2 clk = ~clk;
  tsec_top i_dut (.MCLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SRC_IRQ(src), .DED_EVT(ded),
    .SW_IRQ(sw), .SUPERVISOR(sup), .GLOBAL_ENABLE(gen),
    .GLOBAL_DISABLE(gdis), .CORE_IDLE(idle), .EVT_ACCEPT(acc),
    .EVT_RETURN(ret), .RETURN_NUM(rnum), .EVT_REQ(req), .EVT_NUM(num),
    .WAKEUP(wake));
  tsec_core_model i_core (.clk(clk), .rst_n(rst_b), .req(req), .num(num),
    .hold(hold), .pop(pop), .accept(acc), .ret(ret), .ret_num(rnum));
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 16) begin
      failures++;
      test_done();
    end
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  // bounded wait, sampled mid-cycle where outputs have settled
  task automatic wt(input int sel);
    int n;
    logic v;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      v = sel == 0 ? req : sel == 1 ? acc : wake;
    end while (v !== 1'b1 && n < 40);
    if (v !== 1'b1) begin
      failures++;
      test_done();
    end
  endtask : wt
  initial begin
    int lv;
    for (int s = 0; s < 32; s++) begin
      lv = s < 3 ? 0 : s < 5 ? 1 : s < 9 ? 2 : s < 16 ? 3 :
        s < 19 ? 4 : s < 29 ? 5 : 6;
      ex[s/8][4*(s%8) +: 4] = 4'(lv);
    end
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    for (int r = 0; r < 4; r++) rdc(12'h020 + 12'(4 * r), ex[r]);
    rdc(12'h004, tsec_pkg::RST_UNMASK);
    rdc(12'h010, 32'h0);
    rdc(12'h018, 32'h0);
    rdc(12'h040, 32'h0);
    sup <= 1'b0;
    rdc(12'h004, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
    sup <= 1'b1;
    rdc(12'h004, tsec_pkg::RST_UNMASK);
    apb(1'b1, 12'h004, 32'h0000_ffff);
    apb(1'b1, 12'h010, 32'h0000_0201);
    gen <= 1'b1;
    @(posedge clk);
    gen <= 1'b0;
    src <= 32'h0000_0208;
    wt(0);
    chk({28'h0, num}, 32'ha);
    rdc(12'h014, 32'h0000_0208);
    rdc(12'h000, 32'h0000_0400);
    hold <= 1'b0;
    wt(1);
    rdc(12'h008, 32'h0000_0400);
    rdc(12'h000, 32'h0);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    repeat (2) @(negedge clk);
    chk({31'h0, req}, 32'h0);
    @(posedge clk);
    src <= 32'h0;
    ex[1][7:4] = 4'h7;
    apb(1'b1, 12'h024, ex[1]);
    src <= 32'h0000_0200;
    wt(0);
    chk({28'h0, num}, 32'he);
    wt(1);
    @(posedge clk);
    src <= 32'h0000_0201;
    wt(0);
    chk({28'h0, num}, 32'h7);
    wt(1);
    rdc(12'h008, 32'h0000_4080);
    apb(1'b1, 12'h018, 32'h0000_0008);
    idle <= 1'b1;
    src <= 32'h0000_0209;
    wt(2);
    chk({31'h0, wake}, 32'h1);
    @(posedge clk);
    gdis <= 1'b1;
    @(posedge clk);
    gdis <= 1'b0;
    test_done();
  end
endmodule : tsec_top_tb
